// [hdl/main_clock_ctrl_rtc_beeper.sv]
// Main clock controller: CPU prescaler, clock-out, time base, beeper, APB registers
//
// How it works
// - Slow mode divides by 2, 4, 8, 16
// - Slow select off gives full oscillator rate
// - Control bit 7 enables clock-out pin
// - Clock-out stops toggling in active-halt
// - Time-base field selects four counter periods
// - New time base applies after current period
// - Period end sets the timeout flag
// - Reading control/status clears the timeout flag
// - Interrupt only when interrupt enable set
// - Halt with enable set enters active-halt
// - Wait unaffected; interrupt ends wait
// - Active-halt: counter runs, registers frozen, wakes
// - Full halt freezes all; other wake only
// - Tone field selects off or three tones
// - Tone keeps running in active-halt
// - Both registers reset to zero
`timescale 1ns/1ps
`include "mcc_defs.svh"

module main_clock_ctrl_rtc_beeper
  import mcc_pkg::*;
#(
  parameter int unsigned RTC_TB0    = `RTC_PERIOD_TB0,
  parameter int unsigned RTC_TB1    = `RTC_PERIOD_TB1,
  parameter int unsigned RTC_TB2    = `RTC_PERIOD_TB2,
  parameter int unsigned RTC_TB3    = `RTC_PERIOD_TB3,
  parameter int unsigned BEEP_HALF1 = `BEEP_OSC_HZ / (2 * `BEEP_HZ_SEL1),
  parameter int unsigned BEEP_HALF2 = `BEEP_OSC_HZ / (2 * `BEEP_HZ_SEL2),
  parameter int unsigned BEEP_HALF3 = `BEEP_OSC_HZ / (2 * `BEEP_HZ_SEL3)
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // CPU core side
  input  wire logic        halt_req,
  input  wire logic        wake_other,
  output logic             cpu_tick,
  output logic             irq,
  output logic             active_halt,
  output logic             full_halt,
  // Alternate function pins
  output logic             clock_out_pin,
  output logic             clock_out_oe_n,
  output logic             tone_pin,
  output logic             tone_oe_n
);

  localparam logic [7:0] CSR_ADDR  = `CSR_INDEX << 2;
  localparam logic [7:0] BEEP_ADDR = `BEEP_INDEX << 2;

  state_t st_q;
  state_t st_d;

  period_if rtc ();
  period_if beep ();

  logic       setup;
  logic       access;
  logic       hit_csr;
  logic       hit_beep;
  logic       frozen;
  logic       rd_clear_now;
  logic [7:0] csr_rd;
  logic [7:0] beep_rd;
  logic [2:0] target_shift;
  logic [4:0] ratio;
  logic [3:0] div_last;

  period_counter u_rtc
  (
    .pclk    (pclk),
    .presetn (presetn),
    .cnt     (rtc)
  );

  period_counter u_beep
  (
    .pclk    (pclk),
    .presetn (presetn),
    .cnt     (beep)
  );

  // Time base runs in run and active-halt, stops in full halt
  assign rtc.run  = (st_q.mode != PM_HALT);
  assign rtc.clr  = 1'b0;

  always_comb
  begin
    unique case (st_q.tb_active)
      2'b00: rtc.last = `CNT_W'(RTC_TB0 - 1);
      2'b01: rtc.last = `CNT_W'(RTC_TB1 - 1);
      2'b10: rtc.last = `CNT_W'(RTC_TB2 - 1);
      2'b11: rtc.last = `CNT_W'(RTC_TB3 - 1);
    endcase
  end

  // Tone keeps running in active-halt; software turns it off
  assign beep.run = (st_q.tone_select != 2'b00) && (st_q.mode != PM_HALT);
  assign beep.clr = (st_q.tone_select == 2'b00);

  always_comb
  begin
    unique case (st_q.tone_select)
      2'b01:   beep.last = `CNT_W'(BEEP_HALF1 - 1);
      2'b10:   beep.last = `CNT_W'(BEEP_HALF2 - 1);
      2'b11:   beep.last = `CNT_W'(BEEP_HALF3 - 1);
      2'b00:   beep.last = '0;
    endcase
  end

  assign setup    = psel && !penable;
  assign access   = psel && penable && st_q.pready;
  assign hit_csr  = (paddr == CSR_ADDR);
  assign hit_beep = (paddr == BEEP_ADDR);
  assign frozen   = (st_q.mode != PM_RUN);

  assign csr_rd  = {st_q.clock_out_enable, st_q.cpu_divider_select, st_q.slow_select,
                    st_q.time_base_select, st_q.osc_irq_enable, st_q.timeout_flag};
  assign beep_rd = {6'h00, st_q.tone_select};

  // Only the flag value actually returned is cleared, so a new event is kept
  assign rd_clear_now = access && !pwrite && hit_csr && st_q.rd_clear && !frozen;

  assign target_shift = st_q.slow_select ? (3'({1'b0, st_q.cpu_divider_select}) + 3'h1) : 3'h0;
  assign ratio        = 5'h01 << st_q.shift;
  assign div_last     = 4'(ratio - 5'h01);

  always_comb
  begin
    st_d          = st_q;
    st_d.pready   = 1'b0;
    st_d.pslverr  = 1'b0;
    st_d.cpu_tick = 1'b0;

    // APB setup: decode and capture read data for the access phase
    if (setup)
    begin
      st_d.pready   = 1'b1;
      st_d.pslverr  = !(hit_csr || hit_beep);
      st_d.prdata   = hit_csr ? csr_rd : (hit_beep ? beep_rd : 8'h00);
      st_d.rd_clear = hit_csr && !pwrite && csr_rd[`CSR_OIF_BIT];
    end

    // Writes are lost while the registers are frozen
    if (access && pwrite && !frozen)
    begin
      if (hit_csr)
      begin
        st_d.clock_out_enable   = pwdata[`CSR_MCO_BIT];
        st_d.cpu_divider_select = pwdata[`CSR_CP_MSB:`CSR_CP_LSB];
        st_d.slow_select        = pwdata[`CSR_SMS_BIT];
        st_d.time_base_select   = pwdata[`CSR_TB_MSB:`CSR_TB_LSB];
        st_d.osc_irq_enable     = pwdata[`CSR_OIE_BIT];
      end
      if (hit_beep)
      begin
        // Reserved bits are expected zero and are not stored
        st_d.tone_select = pwdata[`BEEP_BC_MSB:`BEEP_BC_LSB];
      end
    end

    // Set wins over the read clear
    st_d.timeout_flag = (st_q.timeout_flag && !rd_clear_now) || rtc.wrap;

    // New time base taken only at the end of the running period
    if (rtc.wrap)
    begin
      st_d.tb_active = st_q.time_base_select;
    end

    // CPU prescaler; ratio reloads only at a period end, so no short pulse
    if (st_q.mode == PM_RUN)
    begin
      if (st_q.div_cnt >= div_last)
      begin
        st_d.div_cnt  = 4'h0;
        st_d.cpu_tick = 1'b1;
        st_d.shift    = target_shift;
      end
      else
      begin
        st_d.div_cnt = st_q.div_cnt + 4'h1;
      end
    end
    else
    begin
      st_d.div_cnt = 4'h0;
    end

    // Clock-out toggles at each CPU tick, parked low in either halt
    if (st_q.clock_out_enable && st_q.mode == PM_RUN)
    begin
      if (st_d.cpu_tick)
      begin
        st_d.clock_out_pin = !st_q.clock_out_pin;
      end
    end
    else
    begin
      st_d.clock_out_pin = 1'b0;
    end

    // Tone square wave, about half duty
    if (st_q.tone_select == 2'b00)
    begin
      st_d.tone_pin = 1'b0;
    end
    else if (beep.wrap)
    begin
      st_d.tone_pin = !st_q.tone_pin;
    end

    // Power modes; wait mode needs nothing here, the interrupt ends it
    unique case (st_q.mode)
      PM_RUN:
      begin
        if (halt_req)
        begin
          st_d.mode = st_q.osc_irq_enable ? PM_ACTIVE_HALT : PM_HALT;
        end
      end
      PM_ACTIVE_HALT:
      begin
        if (st_q.irq || wake_other)
        begin
          st_d.mode = PM_RUN;
        end
      end
      PM_HALT:
      begin
        if (wake_other)
        begin
          st_d.mode = PM_RUN;
        end
      end
      default:
      begin
        st_d.mode = PM_RUN;
      end
    endcase

    st_d.in_active_halt = (st_d.mode == PM_ACTIVE_HALT);
    st_d.in_halt        = (st_d.mode == PM_HALT);
    // Level request; the CPU mask gates delivery outside
    st_d.irq = st_d.timeout_flag && st_d.osc_irq_enable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign prdata         = {24'h000000, st_q.prdata};
  assign pready         = st_q.pready;
  assign pslverr        = st_q.pslverr;
  assign cpu_tick       = st_q.cpu_tick;
  assign irq            = st_q.irq;
  assign active_halt    = st_q.in_active_halt;
  assign full_halt      = st_q.in_halt;
  assign clock_out_pin  = st_q.clock_out_pin;
  assign clock_out_oe_n = !st_q.clock_out_enable;
  assign tone_pin       = st_q.tone_pin;
  assign tone_oe_n      = (st_q.tone_select == 2'b00);

  default clocking cb @(posedge pclk);
  endclocking

  default disable iff (!presetn);

  property p_normal_rate;
    (st_q.cpu_tick && st_q.shift == 3'h0 && !st_q.slow_select && st_q.mode == PM_RUN)
      |=> st_q.cpu_tick;
  endproperty
  a_normal_rate: assert property (p_normal_rate) else $error("normal mode tick missing");

  property p_slow_gap;
    (st_q.cpu_tick && st_q.shift == 3'h2)
      |=> !st_q.cpu_tick [*3];
  endproperty
  a_slow_gap: assert property (p_slow_gap) else $error("divide by 4 tick too early");

  property p_clkout_stop;
    (st_q.mode == PM_ACTIVE_HALT) |=> !st_q.clock_out_pin;
  endproperty
  a_clkout_stop: assert property (p_clkout_stop) else $error("clock-out toggles in active-halt");

  property p_flag_set;
    rtc.wrap |=> st_q.timeout_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("timeout flag not set");

  property p_read_clear;
    (psel && penable && pready && !pwrite && paddr == CSR_ADDR && st_q.mode == PM_RUN
      && prdata[`CSR_OIF_BIT] && !rtc.wrap) |=> !st_q.timeout_flag;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag not cleared by read");

  property p_irq_level;
    (st_q.timeout_flag && st_q.osc_irq_enable) |-> st_q.irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

  property p_irq_drop;
    !st_q.timeout_flag |-> !st_q.irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("interrupt held after flag clear");

  property p_irq_gated;
    !st_q.osc_irq_enable |-> !st_q.irq;
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("interrupt without enable");

  property p_active_entry;
    (st_q.mode == PM_RUN && halt_req && st_q.osc_irq_enable) |=> st_q.in_active_halt;
  endproperty
  a_active_entry: assert property (p_active_entry) else $error("wrong halt kind");

  property p_halt_freeze;
    (st_q.mode == PM_HALT && !wake_other) |=> ($stable(rtc.count) && st_q.mode == PM_HALT);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("full halt not frozen");

  property p_tb_hold;
    !rtc.wrap |=> $stable(st_q.tb_active);
  endproperty
  a_tb_hold: assert property (p_tb_hold) else $error("time base changed mid period");

  property p_tone_off;
    (st_q.tone_select == 2'b00) |=> !st_q.tone_pin;
  endproperty
  a_tone_off: assert property (p_tone_off) else $error("tone pin active while off");

  property p_active_wake;
    (st_q.mode == PM_ACTIVE_HALT && st_q.irq) |=> (st_q.mode == PM_RUN);
  endproperty
  a_active_wake: assert property (p_active_wake) else $error("no wake from active-halt");

  c_slow16: cover property (st_q.cpu_tick && st_q.shift == 3'h4);
  c_active_wake: cover property (st_q.mode == PM_ACTIVE_HALT ##1 st_q.mode == PM_RUN);
  c_tone_toggle: cover property (st_q.tone_select != 2'b00 && beep.wrap);
  c_flag_read: cover property (rd_clear_now);

endmodule

// [hdl/mcc_defs.svh]
// Register map, field positions, reset values and counts of the main clock controller
`ifndef MCC_DEFS_SVH
`define MCC_DEFS_SVH

// Register indexes; the byte address is four times the index
`define CSR_INDEX      8'h2c
`define BEEP_INDEX     8'h2d

// Control/status fields
`define CSR_MCO_BIT    7
`define CSR_CP_MSB     6
`define CSR_CP_LSB     5
`define CSR_SMS_BIT    4
`define CSR_TB_MSB     3
`define CSR_TB_LSB     2
`define CSR_OIE_BIT    1
`define CSR_OIF_BIT    0
`define CSR_RESET      8'h00

// Beep control fields
`define BEEP_BC_MSB    1
`define BEEP_BC_LSB    0
`define BEEP_RESET     8'h00

// Time-base periods in oscillator cycles
`define RTC_PERIOD_TB0 16000
`define RTC_PERIOD_TB1 32000
`define RTC_PERIOD_TB2 80000
`define RTC_PERIOD_TB3 200000

// Tone frequencies in Hz at the reference oscillator rate
`define BEEP_OSC_HZ    8000000
`define BEEP_HZ_SEL1   2000
`define BEEP_HZ_SEL2   1000
`define BEEP_HZ_SEL3   500

// Width of the shared period counter
`define CNT_W          18

`endif

// [hdl/mcc_pkg.sv]
// Types shared by the main clock controller modules
`include "mcc_defs.svh"

package mcc_pkg;

  typedef enum logic [1:0] {PM_RUN, PM_ACTIVE_HALT, PM_HALT} power_mode_t;

  typedef struct packed {
    logic [`CNT_W-1:0] count;
  } cnt_state_t;

  typedef struct packed {
    logic              clock_out_enable;
    logic [1:0]        cpu_divider_select;
    logic              slow_select;
    logic [1:0]        time_base_select;
    logic              osc_irq_enable;
    logic              timeout_flag;
    logic [1:0]        tone_select;
    logic [1:0]        tb_active;
    logic [2:0]        shift;
    logic [3:0]        div_cnt;
    logic              cpu_tick;
    logic              clock_out_pin;
    logic              tone_pin;
    power_mode_t       mode;
    logic              in_active_halt;
    logic              in_halt;
    logic [7:0]        prdata;
    logic              pready;
    logic              pslverr;
    logic              rd_clear;
    logic              irq;
  } state_t;

endpackage

// [hdl/period_if.sv]
// Connection between a period owner and a period counter
`timescale 1ns/1ps
`include "mcc_defs.svh"

interface period_if;
  logic              run;
  logic              clr;
  logic [`CNT_W-1:0] last;
  logic [`CNT_W-1:0] count;
  logic              wrap;

  modport owner   (output run, output clr, output last, input count, input wrap);
  modport counter (input run, input clr, input last, output count, output wrap);
endinterface

// [hdl/period_counter.sv]
// Free counter that wraps after a programmable last value
`timescale 1ns/1ps
`include "mcc_defs.svh"

module period_counter
  import mcc_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Owner side
  period_if.counter cnt
);

  cnt_state_t st_q;
  cnt_state_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (cnt.clr)
    begin
      st_d.count = '0;
    end
    else if (cnt.run)
    begin
      // Compare with >= so a shortened period never overruns
      st_d.count = (st_q.count >= cnt.last) ? '0 : st_q.count + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign cnt.count = st_q.count;
  assign cnt.wrap  = cnt.run && !cnt.clr && (st_q.count >= cnt.last);

endmodule

// [tb/cpu_core_model.sv]
// Model of the CPU core that consumes the divided clock and asks for halt
`timescale 1ns/1ps

module cpu_core_model
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bench commands, one-cycle pulses
  input  wire logic cmd_halt,
  input  wire logic cmd_wake,
  // Controller side
  input  wire logic cpu_tick,
  input  wire logic active_halt,
  input  wire logic full_halt,
  output logic      halt_req,
  output logic      wake_other,
  output int        ticks
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      halt_req   <= 1'b0;
      wake_other <= 1'b0;
      ticks      <= 0;
    end
    else
    begin
      // A stopped core cannot execute a halt instruction
      halt_req   <= cmd_halt && !active_halt && !full_halt;
      wake_other <= cmd_wake && full_halt;
      ticks      <= ticks + int'(cpu_tick);
    end
  end
endmodule

// [tb/main_clock_ctrl_rtc_beeper_tb_top.sv]
// Self-checking bench of the main clock controller over APB
`timescale 1ns/1ps
`include "mcc_defs.svh"

module main_clock_ctrl_rtc_beeper_tb_top;
  localparam logic [7:0] A_CSR  = 8'(`CSR_INDEX * 4);
  localparam logic [7:0] A_BEEP = 8'(`BEEP_INDEX * 4);
  localparam int         LIMIT  = 20000;
  // Shortened periods so every setting is seen in a short run
  localparam int         RT0 = 20, RT1 = 30, RT2 = 40, RT3 = 50;
  localparam int         BH1 = 3, BH2 = 4, BH3 = 5;
  int per[4]  = '{RT0, RT1, RT2, RT3};
  int half[4] = '{0, BH1, BH2, BH3};

  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, halt_req, wake_other, cpu_tick, irq;
  logic        active_halt, full_halt, clock_out_pin, clock_out_oe_n, tone_pin, tone_oe_n;
  logic        cmd_halt, cmd_wake, tone_prev, irq_prev;
  int          ticks, failures, checked, cyc, t0, t1, t2, nt, nc, nn, cur, k;

  main_clock_ctrl_rtc_beeper #(.RTC_TB0(RT0), .RTC_TB1(RT1), .RTC_TB2(RT2), .RTC_TB3(RT3),
    .BEEP_HALF1(BH1), .BEEP_HALF2(BH2), .BEEP_HALF3(BH3)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_req(halt_req), .wake_other(wake_other), .cpu_tick(cpu_tick), .irq(irq),
    .active_halt(active_halt), .full_halt(full_halt), .clock_out_pin(clock_out_pin),
    .clock_out_oe_n(clock_out_oe_n), .tone_pin(tone_pin), .tone_oe_n(tone_oe_n));

  cpu_core_model core (.pclk(pclk), .presetn(presetn), .cmd_halt(cmd_halt), .cmd_wake(cmd_wake),
    .cpu_tick(cpu_tick), .active_halt(active_halt), .full_halt(full_halt),
    .halt_req(halt_req), .wake_other(wake_other), .ticks(ticks));

  always #10 pclk = ~pclk;

  // Previous levels, read by tasks in the same negedge before the update lands
  always @(negedge pclk)
  begin
    tone_prev <= tone_pin;
    irq_prev  <= irq;
  end

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      failures++;
      tally_and_finish();
    end
  end

  task tally_and_finish();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Setup, access held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Values read here are those that stood just before this edge
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      failures++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Clear a stale flag so the next interrupt rise marks a real period end
  task flush();
    apb(1'b0, A_CSR, 32'h0);
    @(negedge pclk);
    if (irq === 1'b1)
      apb(1'b0, A_CSR, 32'h0);
  endtask

  // Kinds: 0 cpu tick, 1 tone edge, 2 interrupt rise
  task next_ev(input int kind, output int at);
    int  n;
    logic hit;
    n   = 0;
    hit = 1'b0;
    while (!hit && n < 400)
    begin
      @(negedge pclk);
      n++;
      case (kind)
        0:       hit = (cpu_tick === 1'b1);
        1:       hit = (tone_pin !== tone_prev);
        default: hit = (irq === 1'b1 && irq_prev !== 1'b1);
      endcase
    end
    if (!hit)
      failures++;
    at = cyc;
  endtask

  task watch(input int n, output int tk, output int co, output int tn);
    tk = 0;
    co = 0;
    tn = 0;
    repeat (n)
    begin
      @(negedge pclk);
      tk += int'(cpu_tick === 1'b1);
      co += int'(clock_out_pin === 1'b1);
      tn += int'(tone_pin !== tone_prev);
    end
  endtask

  task pulse_halt();
    cmd_halt <= 1'b1;
    @(posedge pclk);
    cmd_halt <= 1'b0;
    repeat (3) @(negedge pclk);
  endtask

  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    cmd_halt = 0; cmd_wake = 0; failures = 0; checked = 0; cyc = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(A_CSR, 32'h0);
    rd_chk(A_BEEP, 32'h0);
    check(32'({clock_out_oe_n, tone_oe_n}), 32'h3);
    apb(1'b0, 8'h00, 32'h0);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    $display("test reset and map done");
    next_ev(0, t0);
    next_ev(0, t1);
    check(32'(t1 - t0), 32'h1);
    for (int cp = 0; cp < 4; cp++)
    begin
      wr(A_CSR, 32'((cp << 5) | 8'h10));
      next_ev(0, t0);
      next_ev(0, t1);
      next_ev(0, t2);
      check(32'(t2 - t1), 32'(2 << cp));
    end
    wr(A_CSR, 32'h80);
    // The slow ratio of the last loop ends only at its next tick
    next_ev(0, t0);
    next_ev(0, t1);
    check(32'(t1 - t0), 32'h1);
    nn = int'(clock_out_pin);
    @(negedge pclk);
    check(32'(int'(clock_out_pin) ^ nn), 32'h1);
    check(32'(clock_out_oe_n), 32'h0);
    wr(A_CSR, 32'h0);
    repeat (3) @(negedge pclk);
    check(32'({clock_out_oe_n, clock_out_pin}), 32'h2);
    $display("test prescaler and clock-out done");
    wr(A_CSR, 32'h02);
    flush();
    cur = 0;
    next_ev(2, t0);
    for (int i = 0; i < 4; i++)
    begin
      k = (i + 1) % 4;
      rd_chk(A_CSR, 32'((cur << 2) | 3));
      @(negedge pclk);
      check(32'(irq), 32'h0);
      rd_chk(A_CSR, 32'((cur << 2) | 2));
      wr(A_CSR, 32'((k << 2) | 2));
      next_ev(2, t1);
      check(32'(t1 - t0), 32'(per[cur]));
      rd_chk(A_CSR, 32'((k << 2) | 3));
      next_ev(2, t2);
      check(32'(t2 - t1), 32'(per[k]));
      t0  = t2;
      cur = k;
    end
    wr(A_CSR, 32'h0);
    watch(60, nt, nc, nn);
    check(32'(irq_prev), 32'h0);
    rd_chk(A_CSR, 32'h01);
    $display("test time base done");
    for (int s = 1; s < 4; s++)
    begin
      wr(A_BEEP, 32'(s));
      rd_chk(A_BEEP, 32'(s));
      next_ev(1, t0);
      next_ev(1, t1);
      next_ev(1, t2);
      check(32'(t2 - t1), 32'(half[s]));
      check(32'(tone_oe_n), 32'h0);
    end
    wr(A_BEEP, 32'h0);
    repeat (8) @(negedge pclk);
    check(32'({tone_oe_n, tone_pin}), 32'h2);
    $display("test beep done");
    wr(A_BEEP, 32'h1);
    wr(A_CSR, 32'h8e);
    flush();
    next_ev(2, t0);
    apb(1'b0, A_CSR, 32'h0);
    pulse_halt();
    check(32'({active_halt, full_halt}), 32'h2);
    wr(A_CSR, 32'h0);
    watch(8, nt, nc, nn);
    check(32'(nt), 32'h0);
    check(32'(nc), 32'h0);
    check(32'(nn > 0), 32'h1);
    next_ev(2, t1);
    check(32'(t1 - t0), 32'(per[3]));
    repeat (3) @(negedge pclk);
    check(32'(active_halt), 32'h0);
    rd_chk(A_CSR, 32'h8f);
    $display("test active halt done");
    wr(A_CSR, 32'h0c);
    pulse_halt();
    check(32'({active_halt, full_halt}), 32'h1);
    watch(120, nt, nc, nn);
    check(32'(nn), 32'h0);
    check(32'(full_halt), 32'h1);
    @(posedge pclk);
    cmd_wake <= 1'b1;
    @(posedge pclk);
    cmd_wake <= 1'b0;
    repeat (3) @(negedge pclk);
    check(32'(full_halt), 32'h0);
    $display("test full halt done");
    wr(A_BEEP, 32'h3);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(A_CSR, 32'h0);
    rd_chk(A_BEEP, 32'h0);
    check(32'({tone_oe_n, tone_pin, active_halt, full_halt}), 32'h8);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
